//--- rtl/misc_regs_pkg.sv
// Package with register map, reset values, pin routing codes and timing constants
package misc_regs_pkg;

	// Register byte offsets
	localparam logic [7:0] general_timer_config_offset = 8'h8c;
	localparam logic [7:0] general_timer_count_offset  = 8'h90;
	localparam logic [7:0] pin_function_offset         = 8'h94;
	localparam logic [7:0] host_word_order_offset      = 8'h98;
	localparam logic [7:0] tick_counter_offset         = 8'h9c;

	// Field positions
	localparam int timer_run_bit     = 29;
	localparam int pin_function_lsb  = 20;
	localparam int output_three_bit  = 3;
	localparam int output_four_bit   = 4;

	// Reset values and the word order swap pattern
	localparam logic [15:0] preload_reset     = 16'hffff;
	localparam logic [15:0] count_reset       = 16'hffff;
	localparam logic [31:0] word_order_reset  = 32'h00000000;
	localparam logic [31:0] word_order_swap   = 32'hffffffff;

	// Timing
	localparam int clock_mhz          = 100;
	localparam int tick_mhz           = 25;
	localparam int tick_divide        = clock_mhz / tick_mhz;
	localparam int timer_tick_ns      = 1000;
	localparam int timer_tick_cycles  = timer_tick_ns * clock_mhz / 1000;
	localparam int tick_settle_ns     = 160;
	localparam int tick_settle_cycles = tick_settle_ns * clock_mhz / 1000;

	typedef enum logic [2:0] {
		pins_serial_memory = 3'h0,
		pins_outputs       = 3'h1,
		pins_out3_rx_valid = 3'h3,
		pins_tx_en_out4    = 3'h5,
		pins_tx_en_rx_dv   = 3'h6,
		pins_mii_clocks    = 3'h7
	} pin_function_type;

	typedef struct packed {
		logic [7:0]  address;
		logic [31:0] write_data;
		logic        write;
		logic        read;
	} bus_request_type;

	typedef struct packed {
		logic tx_en;
		logic rx_dv;
		logic tx_clk;
		logic rx_clk;
	} mii_monitor_type;

endpackage : misc_regs_pkg

//--- rtl/misc_timer_counter_regs.sv
// Timer, tick counter, word order and pin routing registers
`timescale 1ns/1ps

// What this block does
// - Pin selector routes the two serial-memory pins per six legal codes.
// - Writing one to bit 29 starts the general timer.
// - Clearing bit 29 halts the timer count.
// - Falling run bit forces the preload field to FFFFh.
// - Preload in bits 15-0, read/write, resets FFFFh, loads the timer.
// - Timer raises periodic host interrupt events set by its configuration.
// - Count register shows live timer value, read-only, reset FFFFh.
// - Word order matters only in 16-bit mode; 32-bit maps straight.
// - 16-bit, order not all ones: A1 high word, A1 clear low word.
// - 16-bit, order all ones: mapping swapped.
// - Transmit data leaves low word first regardless of word order.
// - Receive data enters low word first regardless of word order.
// - 32-bit tick counter starts at zero and counts 25 MHz cycles.
// - Tick counter wraps to zero after maximum.
// - In 16-bit mode the tick count is captured on the first half read.
// - Tick counter may take up to 160 ns to read zero after reset.
// - Tick counter runs in every power state.
module misc_timer_counter_regs #(
	parameter int timer_tick_cycles = misc_regs_pkg::timer_tick_cycles
) (
	// Clock and reset
	input  wire logic                          clock,
	input  wire logic                          arst_n,
	// Register port
	input  wire misc_regs_pkg::bus_request_type bus,
	input  wire logic                          half_bus_mode,
	input  wire logic                          half_address_one,
	output logic [31:0]                        read_data,
	// Data path word mapping
	input  wire logic [31:0]                   tx_fifo_word,
	output logic [15:0]                        tx_half_word,
	output logic                               tx_half_is_high,
	input  wire logic [15:0]                   rx_half_word,
	input  wire logic                          rx_half_strobe,
	output logic [31:0]                        rx_fifo_word,
	output logic                               rx_fifo_word_valid,
	input  wire logic                          tx_half_advance,
	// Events and pins
	output logic                               timer_event,
	input  wire logic                          mii_tx_en,
	input  wire logic                          mii_rx_dv,
	input  wire logic                          mii_tx_clk,
	input  wire logic                          mii_rx_clk,
	input  wire logic                          serial_memory_data_out,
	input  wire logic                          serial_memory_data_oe,
	input  wire logic                          serial_memory_clock_out,
	output logic                               serial_memory_data_pin_out,
	output logic                               serial_memory_data_pin_oe,
	output logic                               serial_memory_clock_pin_out,
	output logic                               serial_memory_clock_pin_oe,
	output logic                               tick_settled
);

	logic        reset_meta_n;
	logic        reset_n;
	logic        timer_run;
	logic [15:0] timer_preload_value;
	logic [15:0] timer_current_count;
	logic [31:0] word_order;
	logic [2:0]  pin_function_select;
	logic        output_three;
	logic        output_four;
	logic [31:0] tick_count;
	logic [31:0] tick_latch;
	logic        tick_latched;
	logic [1:0]  tick_divider;
	logic        tick_enable;
	logic [$clog2(timer_tick_cycles + 1)-1:0] timer_divider;
	logic        timer_tick;
	logic [3:0]  mii_sync0;
	logic [3:0]  mii_sync1;
	logic [3:0]  mii_sync2;
	logic [3:0]  mii_level;
	logic [4:0]  settle_count;
	logic        swap;
	logic        high_half;
	logic [31:0] next_read_data;
	logic        rx_low_held;
	logic [15:0] rx_low_word;
	logic [31:0] timer_config_image;
	logic [31:0] pin_function_image;
	logic [31:0] timer_config_write;
	logic [31:0] word_order_write;
	logic [31:0] pin_function_write;

	wire logic write_timer_config = bus.write && bus.address == misc_regs_pkg::general_timer_config_offset;
	wire logic read_tick          = bus.read && bus.address == misc_regs_pkg::tick_counter_offset;

	// Pick the half that a 16-bit access reaches
	function automatic logic [15:0] pick_half(input logic [31:0] word, input logic upper);
		pick_half = upper ? word[31:16] : word[15:0];
	endfunction : pick_half

	// Merge a 16-bit write into the half it reaches; a full-width write passes whole
	function automatic logic [31:0] merge_half(input logic [31:0] old, input logic [31:0] data, input logic half,
		input logic upper);
		if (!half) begin
			merge_half = data;
		end else if (upper) begin
			merge_half = {data[15:0], old[15:0]};
		end else begin
			merge_half = {old[31:16], data[15:0]};
		end
	endfunction : merge_half

	// Current register images, shared by readback and 16-bit half writes
	assign timer_config_image = {2'h0, timer_run, 13'h0, timer_preload_value};
	assign pin_function_image = {9'h0, pin_function_select, 15'h0, output_four, output_three, 3'h0};

	// A 16-bit write must leave the other half of the register untouched; only a falling run bit still forces the preload to FFFFh
	assign timer_config_write = merge_half(timer_config_image, bus.write_data, half_bus_mode, high_half);
	assign word_order_write   = merge_half(word_order, bus.write_data, half_bus_mode, high_half);
	assign pin_function_write = merge_half(pin_function_image, bus.write_data, half_bus_mode, high_half);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			reset_meta_n <= 1'b0;
			reset_n      <= 1'b0;
		end else begin
			reset_meta_n <= 1'b1;
			reset_n      <= reset_meta_n;
		end
	end

	// 25 MHz enable from the 100 MHz clock; nothing here is gated by power state
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_divider <= 2'h0;
		end else begin
			tick_divider <= (tick_divider == 2'(misc_regs_pkg::tick_divide - 1)) ? 2'h0 : tick_divider + 2'h1;
		end
	end
	assign tick_enable = tick_divider == 2'(misc_regs_pkg::tick_divide - 1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_count <= 32'h0;
		end else if (tick_enable) begin
			tick_count <= tick_count + 32'h1;
		end
	end

	// Settling flag on the tick_settled output shows when the count is trustworthy after reset; no register reads it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			settle_count <= 5'h0;
		end else if (settle_count != 5'(misc_regs_pkg::tick_settle_cycles)) begin
			settle_count <= settle_count + 5'h1;
		end
	end
	assign tick_settled = settle_count == 5'(misc_regs_pkg::tick_settle_cycles);

	// Half reads: first read of either half latches, the other half comes from the latch
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tick_latch   <= 32'h0;
			tick_latched <= 1'b0;
		end else if (read_tick && half_bus_mode) begin
			if (!tick_latched) begin
				tick_latch   <= tick_count;
				tick_latched <= 1'b1;
			end else begin
				tick_latched <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			timer_run           <= 1'b0;
			timer_preload_value <= misc_regs_pkg::preload_reset;
		end else if (write_timer_config) begin
			timer_run <= timer_config_write[misc_regs_pkg::timer_run_bit];
			if (timer_run && !timer_config_write[misc_regs_pkg::timer_run_bit]) begin
				timer_preload_value <= misc_regs_pkg::preload_reset;
			end else begin
				timer_preload_value <= timer_config_write[15:0];
			end
		end
	end

	// Timer tick base is a parameter so simulation can shorten it
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			timer_divider <= '0;
		end else if (!timer_run || timer_tick) begin
			timer_divider <= '0;
		end else begin
			timer_divider <= timer_divider + 1'b1;
		end
	end
	assign timer_tick = timer_run && timer_divider == ($bits(timer_divider))'(timer_tick_cycles - 1);

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			timer_current_count <= misc_regs_pkg::count_reset;
			timer_event         <= 1'b0;
		end else begin
			timer_event <= 1'b0;
			// Starting loads the count so the first interval already follows the new preload
			if (write_timer_config && !timer_run && timer_config_write[misc_regs_pkg::timer_run_bit]) begin
				timer_current_count <= timer_config_write[15:0];
			end else if (timer_tick) begin
				if (timer_current_count == 16'h0) begin
					timer_current_count <= timer_preload_value;
					timer_event         <= 1'b1;
				end else begin
					timer_current_count <= timer_current_count - 16'h1;
				end
			end
		end
	end

	// Selector holds whatever is written; reserved codes are the host's to avoid
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			word_order          <= misc_regs_pkg::word_order_reset;
			pin_function_select <= 3'h0;
			output_three        <= 1'b0;
			output_four         <= 1'b0;
		end else if (bus.write) begin
			if (bus.address == misc_regs_pkg::host_word_order_offset) begin
				word_order <= word_order_write;
			end
			if (bus.address == misc_regs_pkg::pin_function_offset) begin
				pin_function_select <= pin_function_write[misc_regs_pkg::pin_function_lsb +: 3];
				output_three        <= pin_function_write[misc_regs_pkg::output_three_bit];
				output_four         <= pin_function_write[misc_regs_pkg::output_four_bit];
			end
		end
	end

	assign swap      = half_bus_mode && word_order == misc_regs_pkg::word_order_swap;
	assign high_half = half_address_one ^ swap;

	always_comb begin
		next_read_data = 32'h0;
		case (bus.address)
			misc_regs_pkg::general_timer_config_offset: begin
				next_read_data = timer_config_image;
			end
			misc_regs_pkg::general_timer_count_offset: begin
				next_read_data = {16'h0, timer_current_count};
			end
			misc_regs_pkg::pin_function_offset: begin
				next_read_data = pin_function_image;
			end
			misc_regs_pkg::host_word_order_offset: begin
				next_read_data = word_order;
			end
			misc_regs_pkg::tick_counter_offset: begin
				next_read_data = (half_bus_mode && tick_latched) ? tick_latch : tick_count;
			end
			default: begin
				next_read_data = 32'h0;
			end
		endcase
		if (half_bus_mode) begin
			next_read_data = {16'h0, pick_half(next_read_data, high_half)};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			read_data <= 32'h0;
		end else if (bus.read) begin
			read_data <= next_read_data;
		end
	end

	// Network side ignores word order entirely
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			tx_half_is_high <= 1'b0;
			tx_half_word    <= 16'h0;
		end else begin
			if (tx_half_advance) begin
				tx_half_is_high <= !tx_half_is_high;
			end
			tx_half_word <= pick_half(tx_fifo_word, tx_half_advance ? !tx_half_is_high : tx_half_is_high);
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rx_low_held        <= 1'b0;
			rx_low_word        <= 16'h0;
			rx_fifo_word       <= 32'h0;
			rx_fifo_word_valid <= 1'b0;
		end else begin
			rx_fifo_word_valid <= 1'b0;
			// A lone low half waits for its partner; nothing times it out
			if (rx_half_strobe) begin
				if (!rx_low_held) begin
					rx_low_word <= rx_half_word;
					rx_low_held <= 1'b1;
				end else begin
					rx_fifo_word       <= {rx_half_word, rx_low_word};
					rx_fifo_word_valid <= 1'b1;
					rx_low_held        <= 1'b0;
				end
			end
		end
	end

	// MII monitor inputs come from another domain
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			mii_sync0 <= 4'h0;
			mii_sync1 <= 4'h0;
			mii_sync2 <= 4'h0;
			mii_level <= 4'h0;
		end else begin
			mii_sync0 <= {mii_tx_en, mii_rx_dv, mii_tx_clk, mii_rx_clk};
			mii_sync1 <= mii_sync0;
			mii_sync2 <= mii_sync1;
			for (int i = 0; i < 4; i++) begin
				if (mii_sync1[i] == mii_sync2[i]) begin
					mii_level[i] <= mii_sync2[i];
				end
			end
		end
	end

	always_comb begin
		serial_memory_data_pin_out  = 1'b0;
		serial_memory_data_pin_oe   = 1'b1;
		serial_memory_clock_pin_out = 1'b0;
		serial_memory_clock_pin_oe  = 1'b1;
		case (pin_function_select)
			misc_regs_pkg::pins_serial_memory: begin
				serial_memory_data_pin_out  = serial_memory_data_out;
				serial_memory_data_pin_oe   = serial_memory_data_oe;
				serial_memory_clock_pin_out = serial_memory_clock_out;
			end
			misc_regs_pkg::pins_outputs: begin
				serial_memory_data_pin_out  = output_three;
				serial_memory_clock_pin_out = output_four;
			end
			misc_regs_pkg::pins_out3_rx_valid: begin
				serial_memory_data_pin_out  = output_three;
				serial_memory_clock_pin_out = mii_level[2];
			end
			misc_regs_pkg::pins_tx_en_out4: begin
				serial_memory_data_pin_out  = mii_level[3];
				serial_memory_clock_pin_out = output_four;
			end
			misc_regs_pkg::pins_tx_en_rx_dv: begin
				serial_memory_data_pin_out  = mii_level[3];
				serial_memory_clock_pin_out = mii_level[2];
			end
			misc_regs_pkg::pins_mii_clocks: begin
				serial_memory_data_pin_out  = mii_level[1];
				serial_memory_clock_pin_out = mii_level[0];
			end
			default: begin
				// Reserved codes: release both pins
				serial_memory_data_pin_oe  = 1'b0;
				serial_memory_clock_pin_oe = 1'b0;
			end
		endcase
	end

endmodule : misc_timer_counter_regs

//--- testbench/host_bus_model.sv
// Host bus master issuing register reads and writes
`timescale 1ns/1ps
module host_bus_model (
	// Clock
	input logic				clock,
	// Register port
	input logic [31:0]			read_data,
	output misc_regs_pkg::bus_request_type	bus,
	output logic				half_bus_mode,
	output logic				half_address_one
);
	initial begin
		bus = '0;
		half_bus_mode = 1'b0;
		half_address_one = 1'b0;
	end
	// Callers keep the selector off reserved codes and idle serial memory
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		bus <= '{a, d, 1'b1, 1'b0};
		half_bus_mode <= 1'b0;
		@(posedge clock);
		bus.write <= 1'b0;
	endtask : wr
	task automatic wrh(input logic [7:0] a, input logic a1, input logic [31:0] d);
		@(posedge clock);
		bus <= '{a, d, 1'b1, 1'b0};
		half_bus_mode <= 1'b1;
		half_address_one <= a1;
		@(posedge clock);
		bus.write <= 1'b0;
	endtask : wrh
	task automatic rd(input logic [7:0] a, input logic h, input logic a1, output logic [31:0] d);
		@(posedge clock);
		bus.address <= a;
		bus.read <= 1'b1;
		half_bus_mode <= h;
		half_address_one <= a1;
		@(posedge clock);
		bus.read <= 1'b0;
		@(negedge clock);
		d = read_data;
	endtask : rd
endmodule : host_bus_model

//--- testbench/misc_regs_properties.sv
// Concurrent checks on the ports of the register block
`timescale 1ns/1ps
module misc_regs_properties (
	// Clock and reset
	input logic				clock,
	input logic				arst_n,
	// Register port
	input misc_regs_pkg::bus_request_type	bus,
	input logic				half_bus_mode,
	input logic				half_address_one,
	input logic [31:0]			read_data,
	// Data path
	input logic				tx_half_advance,
	input logic				tx_half_is_high,
	input logic [15:0]			rx_half_word,
	input logic				rx_half_strobe,
	input logic [31:0]			rx_fifo_word,
	input logic				rx_fifo_word_valid,
	// Events and pins
	input logic				timer_event,
	input logic				serial_memory_data_out,
	input logic				serial_memory_data_oe,
	input logic				serial_memory_clock_out,
	input logic				serial_memory_data_pin_out,
	input logic				serial_memory_data_pin_oe,
	input logic				serial_memory_clock_pin_out,
	input logic				serial_memory_clock_pin_oe
);
	logic [31:0]	pins_q;
	logic [31:0]	order_q;
	logic		run_q;
	logic [15:0]	order_half;
	wire		wr32 = bus.write && !half_bus_mode;
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// Shadows follow full-width writes only; bench 16-bit writes leave the run bit at zero
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pins_q <= '0;
			order_q <= '0;
			run_q <= 1'b0;
		end else if (wr32) begin
			if (bus.address == 8'h94) pins_q <= bus.write_data;
			if (bus.address == 8'h98) order_q <= bus.write_data;
			if (bus.address == 8'h8c) run_q <= bus.write_data[29];
		end
	end
	always_comb begin
		order_half = (half_address_one ^ (order_q == 32'hffffffff)) ? order_q[31:16] : order_q[15:0];
	end
	a_pins_serial_memory: assert property (
		pins_q[22:20] == 3'h0 |-> serial_memory_data_pin_out == serial_memory_data_out
		&& serial_memory_data_pin_oe == serial_memory_data_oe && serial_memory_clock_pin_out == serial_memory_clock_out
		&& serial_memory_clock_pin_oe) else $error("pins not passing serial memory");
	a_event_single: assert property (
		timer_event |=> !timer_event) else $error("timer event longer than one cycle");
	a_halted_quiet: assert property (
		!run_q [*4] |-> !timer_event) else $error("timer event while halted");
	a_count_upper_zero: assert property (
		bus.read && bus.address == 8'h90 && !half_bus_mode |=> read_data[31:16] == 16'h0)
		else $error("count upper bits set");
	a_order_full: assert property (
		bus.read && bus.address == 8'h98 && !half_bus_mode |=> read_data == order_q)
		else $error("word order readback wrong");
	a_order_half: assert property (
		bus.read && bus.address == 8'h98 && half_bus_mode |=> read_data[15:0] == $past(order_half))
		else $error("half word mapping wrong");
	a_rx_low_first: assert property (
		rx_fifo_word_valid |-> $past(rx_half_strobe) && rx_fifo_word[31:16] == $past(rx_half_word))
		else $error("receive word order wrong");
	a_tx_low_first: assert property (
		tx_half_advance && !tx_half_is_high |=> tx_half_is_high) else $error("transmit half did not step");
	cover property (timer_event);
	cover property (rx_fifo_word_valid);
	cover property (bus.read && half_bus_mode && bus.address == 8'h9c);
endmodule : misc_regs_properties

//--- testbench/misc_timer_counter_regs_tb_top.sv
// Bench for the timer, tick counter, word order and pin routing registers
`timescale 1ns/1ps
module misc_timer_counter_regs_tb_top;
	logic		clock = 1'b0;
	logic		arst_n = 1'b0;
	misc_regs_pkg::bus_request_type	bus;
	logic		half_bus_mode, half_address_one, tx_half_is_high, tx_half_advance, rx_half_strobe;
	logic		rx_fifo_word_valid, timer_event, tick_settled, mii_tx_en, mii_rx_dv, mii_tx_clk, mii_rx_clk;
	logic		serial_memory_data_out, serial_memory_data_oe, serial_memory_clock_out;
	logic		serial_memory_data_pin_out, serial_memory_data_pin_oe;
	logic		serial_memory_clock_pin_out, serial_memory_clock_pin_oe;
	logic [31:0]	read_data, tx_fifo_word, rx_fifo_word, v, w;
	logic [15:0]	tx_half_word, rx_half_word;
	logic [1:0]	e;
	logic [2:0]	codes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
	int		n_mismatch = 0;
	int		samples_checked = 0;
	int		n;
	always #5 clock = ~clock;
	misc_timer_counter_regs #(.timer_tick_cycles(2)) dut (.*);
	host_bus_model host (.clock(clock), .read_data(read_data), .bus(bus), .half_bus_mode(half_bus_mode),
		.half_address_one(half_address_one));
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	// Cycles up to the next timer event; a lost event ends the run
	task automatic next_event(output int k);
		k = 0;
		do begin
			@(negedge clock);
			k++;
		end while (timer_event !== 1'b1 && k < 200);
		if (k >= 200) begin
			n_mismatch++;
			$display("mismatch %0t no timer event", $time);
			complete_run();
		end
	endtask : next_event
	initial begin
		tx_fifo_word = 32'haaaa5555;
		{rx_half_word, rx_half_strobe, tx_half_advance} = '0;
		{mii_tx_en, mii_rx_dv, mii_tx_clk, mii_rx_clk} = '0;
		{serial_memory_data_out, serial_memory_data_oe, serial_memory_clock_out} = 3'h2;
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		host.rd(8'h8c, 0, 0, v); chk(v, 32'h0000ffff);
		host.rd(8'h90, 0, 0, v); chk(v, 32'h0000ffff);
		host.rd(8'h98, 0, 0, v); chk(v, 32'h0);
		host.rd(8'ha0, 0, 0, v); chk(v, 32'h0);
		host.wr(8'h8c, 32'h00001234);
		host.rd(8'h8c, 0, 0, v); chk(v, 32'h00001234);
		host.rd(8'h8c, 1, 1, v); chk(v[15:0], 16'h0000);
		host.rd(8'h8c, 1, 0, v); chk(v[15:0], 16'h1234);
		host.wr(8'h98, 32'hffffffff);
		host.rd(8'h8c, 1, 1, v); chk(v[15:0], 16'h1234);
		host.rd(8'h8c, 1, 0, v); chk(v[15:0], 16'h0000);
		host.rd(8'h8c, 0, 0, v); chk(v, 32'h00001234);
		host.wr(8'h98, 32'h12345678);
		host.rd(8'h98, 1, 1, v); chk(v[15:0], 16'h1234);
		host.wrh(8'h8c, 1'b0, 32'h0000beef);
		host.rd(8'h8c, 0, 0, v); chk(v, 32'h0000beef);
		host.wrh(8'h8c, 1'b1, 32'h00000000);
		host.rd(8'h8c, 0, 0, v); chk(v, 32'h0000beef);
		host.wr(8'h8c, 32'h20000003);
		host.rd(8'h90, 0, 0, v); chk(v <= 32'h3, 1'b1);
		next_event(n);
		next_event(n); chk(n, 8);
		host.wr(8'h8c, 32'h20000001);
		next_event(n);
		next_event(n);
		next_event(n); chk(n, 4);
		host.wr(8'h8c, 32'h00000005);
		host.rd(8'h8c, 0, 0, v); chk(v, 32'h0000ffff);
		host.rd(8'h90, 0, 0, v);
		repeat (20) @(posedge clock);
		host.rd(8'h90, 0, 0, w); chk(w, v);
		host.rd(8'h9c, 0, 0, v);
		repeat (38) @(posedge clock);
		host.rd(8'h9c, 0, 0, w); chk(w - v, 32'd10);
		repeat (38) @(posedge clock);
		host.rd(8'h9c, 1, 0, v); chk(v[15:0], w[15:0] + 16'd10);
		repeat (38) @(posedge clock);
		host.rd(8'h9c, 1, 0, v); chk(v[15:0], w[15:0] + 16'd10);
		repeat (38) @(posedge clock);
		host.rd(8'h9c, 1, 0, v); chk(v[15:0], w[15:0] + 16'd30);
		@(negedge clock); chk({tx_half_is_high, tx_half_word}, 17'h05555);
		@(posedge clock) tx_half_advance <= 1'b1;
		@(posedge clock) tx_half_advance <= 1'b0;
		@(posedge clock);
		@(negedge clock); chk({tx_half_is_high, tx_half_word}, 17'h1aaaa);
		@(posedge clock) {rx_half_strobe, rx_half_word} <= 17'h11111;
		@(posedge clock) rx_half_word <= 16'h2222;
		@(posedge clock) rx_half_strobe <= 1'b0;
		@(negedge clock); chk({rx_fifo_word_valid, rx_fifo_word}, 33'h122221111);
		for (int p = 0; p < 2; p++) begin
			foreach (codes[i]) begin
				host.wr(8'h94, {9'h0, codes[i], 20'h0} | (p[0] ? 32'h10 : 32'h8));
				{mii_tx_en, mii_rx_dv, mii_tx_clk, mii_rx_clk, serial_memory_data_out,
					serial_memory_clock_out} <= 6'h19 ^ {6{p[0]}};
				repeat (8) @(posedge clock);
				@(negedge clock);
				case (codes[i])
					3'h0: e = {serial_memory_data_out, serial_memory_clock_out};
					3'h1: e = {~p[0], p[0]};
					3'h3: e = {~p[0], mii_rx_dv};
					3'h5: e = {mii_tx_en, p[0]};
					3'h6: e = {mii_tx_en, mii_rx_dv};
					default: e = {mii_tx_clk, mii_rx_clk};
				endcase
				chk({serial_memory_data_pin_out, serial_memory_clock_pin_out, serial_memory_data_pin_oe,
					serial_memory_clock_pin_oe}, {e, 2'b11});
			end
		end
		chk(tick_settled, 1'b1);
		complete_run();
	end
endmodule : misc_timer_counter_regs_tb_top
bind misc_timer_counter_regs misc_regs_properties checker_inst (.*);
